//--- rtl/chip_reset_pkg.sv
// constants and types for the chip reset state controller
// assumes a single system clock and a synchronous, active-high reset
//
// Behaviour
// (RQ1) core is halted from reset entry until the reset state is left
// (RQ2) module registers take defaults; power-on-only bits keep value on other resets
// (RQ3) port pins are forced to a known state throughout reset
// (RQ4) all interrupt sources and timers are disabled by reset
// (RQ5) every AHB peripheral clock enable is turned on at reset
// (RQ6) APB clocks off at reset except watchdog, memory interface and dma crossbar
// (RQ7) reset logic never touches on-chip RAM contents
// (RQ8) port output latches reset to one with open-drain drivers
// (RQ9) weak pull-ups on during reset and afterwards until software changes them
// (RQ10) power-on or supply-monitor reset drives reset pin low until reset exits
// (RQ11) reset pin is never driven high, only pulled low with low drive
// (RQ12) on exit program counter reinitialised, internal oscillator selected
// (RQ13) on exit watchdog enabled and clocked from the low frequency oscillator
// (RQ14) first fetch after release is at address zero
// (RQ15) all reset sources combine, hold while any active, release synchronously
package chip_reset_pkg;
  localparam int          NUM_AHB        = 8;
  localparam int          NUM_APB        = 16;
  localparam int          NUM_PINS       = 16;
  localparam int          NUM_SRC        = 4;
  // source bit positions
  localparam int          SRC_POR        = 0;
  localparam int          SRC_VMON       = 1;
  localparam int          SRC_PIN        = 2;
  localparam int          SRC_SOFT       = 3;
  // apb peripheral positions whose clocks survive reset
  localparam int          APB_WDT        = 0;
  localparam int          APB_EMIF       = 1;
  localparam int          APB_DMAX       = 2;
  localparam logic [31:0] BOOT_ADDR      = 32'h0000_0000;
  localparam logic        CLK_SEL_INT    = 1'b0;
  localparam logic        WDT_CLK_LFO    = 1'b0;
  typedef enum logic [1:0] {ST_RESET, ST_RELEASE, ST_RUN} rst_state_t;
endpackage : chip_reset_pkg

//--- rtl/reset_sync.sv
// two-flop synchroniser for an asynchronous level
// assumes the destination clock is the system clock
`timescale 1ns/100ps
`default_nettype none
module reset_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_sys_i,
  input  wire logic         reset_i,
  input  wire logic [W-1:0] async_i,
  output var  logic [W-1:0] sync_o
);
  logic [W-1:0] meta_q;
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      meta_q <= '0;
      sync_o <= '0;
    end
    else
    begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule // reset_sync
`default_nettype wire

//--- rtl/chip_reset_state_controller.sv
// reset state controller: combines reset sources and drives chip-wide defaults
// assumes reset sources are asynchronous pins; ram is outside and untouched
`timescale 1ns/100ps
`default_nettype none
module chip_reset_state_controller
  import chip_reset_pkg::*;
#(
  parameter int NAHB  = chip_reset_pkg::NUM_AHB,
  parameter int NAPB  = chip_reset_pkg::NUM_APB,
  parameter int NPINS = chip_reset_pkg::NUM_PINS
) (
  input  wire logic                                 clk_sys_i,
  input  wire logic                                 reset_i,
  input  wire logic [chip_reset_pkg::NUM_SRC-1:0]   reset_src_i,
  input  wire logic                                 pullup_wr_i,
  input  wire logic [NPINS-1:0]                     pullup_val_i,
  output logic                                      core_halt_o,
  output logic                                      regs_reset_o,
  output logic                                      por_regs_reset_o,
  output logic                                      pins_force_o,
  output logic [NPINS-1:0]                          port_latch_o,
  output logic [NPINS-1:0]                          port_open_drain_o,
  output logic [NPINS-1:0]                          port_pullup_o,
  output logic                                      irq_disable_o,
  output logic                                      timer_disable_o,
  output logic [NAHB-1:0]                           ahb_clk_en_o,
  output logic [NAPB-1:0]                           apb_clk_en_o,
  output logic                                      reset_pin_o,
  output logic                                      reset_pin_oe_o,
  output logic                                      pc_load_o,
  output logic [31:0]                               pc_value_o,
  output logic                                      sysclk_sel_o,
  output logic                                      wdt_enable_o,
  output logic                                      wdt_clk_sel_o
);
  import chip_reset_pkg::*;

  logic [NUM_SRC-1:0] src_s;
  logic               any_src;
  logic               por_cause;
  rst_state_t         state_q;
  localparam logic [NAPB-1:0] APB_KEEP = (NAPB'(1) << APB_WDT) | (NAPB'(1) << APB_EMIF)
                                       | (NAPB'(1) << APB_DMAX);

  // pins are asynchronous, so every source is synchronised first
  // the synchroniser ignores reset_i, so a power-on source seen during it still pulls the pin
  reset_sync #(.W(NUM_SRC)) u_sync (
    .clk_sys_i (clk_sys_i),
    .reset_i   (1'b0),
    .async_i   (reset_src_i),
    .sync_o    (src_s)
  );

  assign any_src   = (|src_s) || reset_i;                         // [RQ15]
  assign por_cause = src_s[SRC_POR] || src_s[SRC_VMON];

  // one cycle of release state gives the core its start strobe
  always_ff @(posedge clk_sys_i)
  begin
    if (any_src)
      state_q <= ST_RESET;                                        // [RQ15]
    else
    begin
      unique case (state_q)
        ST_RESET:   state_q <= ST_RELEASE;
        ST_RELEASE: state_q <= ST_RUN;
        ST_RUN:     state_q <= ST_RUN;
        default:    state_q <= ST_RESET;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (any_src)
    begin
      core_halt_o      <= 1'b1;                                   // [RQ1]
      regs_reset_o     <= 1'b1;                                   // [RQ2]
      por_regs_reset_o <= por_cause;                              // [RQ2]
      pins_force_o     <= 1'b1;                                   // [RQ3]
      irq_disable_o    <= 1'b1;                                   // [RQ4]
      timer_disable_o  <= 1'b1;                                   // [RQ4]
    end
    else
    begin
      core_halt_o      <= 1'b0;
      regs_reset_o     <= 1'b0;
      por_regs_reset_o <= 1'b0;
      pins_force_o     <= 1'b0;
      irq_disable_o    <= 1'b0;
      timer_disable_o  <= 1'b0;
    end
  end

  // clock gating defaults; after release the gates hold their reset values
  always_ff @(posedge clk_sys_i)
  begin
    if (any_src)
    begin
      ahb_clk_en_o <= '1;                                         // [RQ5]
      apb_clk_en_o <= '0;                                         // [RQ6]
      apb_clk_en_o[APB_WDT]  <= 1'b1;                             // [RQ6]
      apb_clk_en_o[APB_EMIF] <= 1'b1;                             // [RQ6]
      apb_clk_en_o[APB_DMAX] <= 1'b1;                             // [RQ6]
    end
  end

  // no ram port exists here, so contents cannot be disturbed [RQ7]
  always_ff @(posedge clk_sys_i)
  begin
    if (any_src)
    begin
      port_latch_o      <= '1;                                    // [RQ8]
      port_open_drain_o <= '1;                                    // [RQ8]
      port_pullup_o     <= '1;                                    // [RQ9]
    end
    else if (pullup_wr_i)
      port_pullup_o     <= pullup_val_i;                          // [RQ9]
  end

  // open drain: level fixed low, enable active low while pulling, never driven high
  always_ff @(posedge clk_sys_i)
  begin
    reset_pin_o <= 1'b0;                                          // [RQ11]
    if (any_src)
      reset_pin_oe_o <= !(por_cause || (!reset_pin_oe_o && state_q == ST_RESET)); // [RQ10]
    else
      reset_pin_oe_o <= 1'b1;                                     // [RQ10]
  end

  always_ff @(posedge clk_sys_i)
  begin
    // the strobe is not gated by a late source: a pc load while the core
    // is halted again is harmless, and it keeps the start path short
    pc_load_o <= (state_q == ST_RELEASE);                         // [RQ12]
    if (any_src)
    begin
      pc_value_o    <= BOOT_ADDR;                                 // [RQ14]
      sysclk_sel_o  <= CLK_SEL_INT;                               // [RQ12]
      wdt_enable_o  <= 1'b0;
      wdt_clk_sel_o <= WDT_CLK_LFO;                               // [RQ13]
    end
    else if (state_q == ST_RELEASE)
      wdt_enable_o  <= 1'b1;                                      // [RQ13]
  end

  reset_hold_a: assert property (@(posedge clk_sys_i)             // [RQ1]
    any_src |=> core_halt_o && irq_disable_o)
    else $error("core not halted during reset");
  clk_default_a: assert property (@(posedge clk_sys_i)            // [RQ6]
    any_src |=> apb_clk_en_o[APB_WDT] && !apb_clk_en_o[NAPB-1] && (&ahb_clk_en_o))
    else $error("clock gate defaults wrong");
  pin_drive_a: assert property (@(posedge clk_sys_i)              // [RQ10]
    por_cause |=> !reset_pin_oe_o)
    else $error("reset pin not pulled low");
  pin_never_high_a: assert property (@(posedge clk_sys_i)         // [RQ11]
    disable iff (reset_i) !reset_pin_o)
    else $error("reset pin driven high");
  sequence s_release; $fell(any_src) ##1 state_q == ST_RELEASE; endsequence
  boot_start_a: assert property (@(posedge clk_sys_i)             // [RQ14]
    s_release |=> pc_load_o && pc_value_o == BOOT_ADDR && wdt_enable_o)
    else $error("boot start wrong");
  latch_one_a: assert property (@(posedge clk_sys_i)              // [RQ8]
    any_src |=> (&port_latch_o) && (&port_open_drain_o) && (&port_pullup_o))
    else $error("port defaults wrong");

  // checks below start from the combined request, except src_reset_a (from reset_i) and load_once_a (from pc_load_o)
  sequence s_exit; $fell(any_src); endsequence
  pin_release_a: assert property (@(posedge clk_sys_i)           // [RQ10]
    s_exit |=> reset_pin_oe_o)
    else $error("reset pin held after release");
  pin_hold_a: assert property (@(posedge clk_sys_i)              // [RQ10]
    any_src && !reset_pin_oe_o |=> !reset_pin_oe_o)
    else $error("reset pin let go inside reset");
  pin_cause_a: assert property (@(posedge clk_sys_i)             // [RQ10]
    any_src && !por_cause && reset_pin_oe_o |=> reset_pin_oe_o)
    else $error("reset pin pulled for wrong cause");
  core_run_a: assert property (@(posedge clk_sys_i)              // [RQ15]
    !any_src |=> !core_halt_o)
    else $error("core still halted after release");
  release_all_a: assert property (@(posedge clk_sys_i)           // [RQ15]
    !any_src |=> !regs_reset_o && !pins_force_o && !irq_disable_o && !timer_disable_o)
    else $error("reset outputs held after release");
  src_reset_a: assert property (@(posedge clk_sys_i)             // [RQ15]
    reset_i |=> core_halt_o && state_q == ST_RESET)
    else $error("reset input not honoured");
  force_all_a: assert property (@(posedge clk_sys_i)             // [RQ3]
    any_src |=> regs_reset_o && pins_force_o && timer_disable_o)
    else $error("reset outputs not forced");
  por_bits_a: assert property (@(posedge clk_sys_i)              // [RQ2]
    any_src && por_cause |=> por_regs_reset_o)
    else $error("power-on-only bits not reset");
  por_keep_a: assert property (@(posedge clk_sys_i)              // [RQ2]
    any_src && !por_cause |=> !por_regs_reset_o)
    else $error("power-on-only bits reset by other cause");
  apb_keep_a: assert property (@(posedge clk_sys_i)              // [RQ6]
    any_src |=> apb_clk_en_o == APB_KEEP)
    else $error("apb gate defaults wrong");
  gates_hold_a: assert property (@(posedge clk_sys_i)            // [RQ5]
    !any_src |=> $stable(ahb_clk_en_o) && $stable(apb_clk_en_o))
    else $error("clock gates moved outside reset");
  latch_hold_a: assert property (@(posedge clk_sys_i)            // [RQ8]
    !any_src |=> $stable(port_latch_o) && $stable(port_open_drain_o))
    else $error("port latches moved outside reset");
  pullup_keep_a: assert property (@(posedge clk_sys_i)           // [RQ9]
    !any_src && !pullup_wr_i |=> $stable(port_pullup_o))
    else $error("pull-ups moved without a write");
  pullup_write_a: assert property (@(posedge clk_sys_i)          // [RQ9]
    !any_src && pullup_wr_i |=> port_pullup_o == $past(pullup_val_i))
    else $error("pull-up write lost");
  wdt_hold_a: assert property (@(posedge clk_sys_i)              // [RQ13]
    wdt_enable_o && !any_src |=> wdt_enable_o)
    else $error("watchdog dropped after start");
  clk_source_a: assert property (@(posedge clk_sys_i)            // [RQ12]
    any_src |=> sysclk_sel_o == CLK_SEL_INT && wdt_clk_sel_o == WDT_CLK_LFO && !wdt_enable_o)
    else $error("clock sources wrong in reset");
  load_once_a: assert property (@(posedge clk_sys_i)             // [RQ12]
    pc_load_o |=> !pc_load_o)
    else $error("pc load longer than one cycle");
  start_clock_a: assert property (@(posedge clk_sys_i)           // [RQ12]
    s_release |-> !core_halt_o && sysclk_sel_o == CLK_SEL_INT)
    else $error("start clock wrong");
  start_wdt_a: assert property (@(posedge clk_sys_i)             // [RQ13]
    s_release |-> wdt_clk_sel_o == WDT_CLK_LFO && !wdt_enable_o)
    else $error("watchdog started too early");
endmodule // chip_reset_state_controller
`default_nettype wire

//--- bench/tb_top.sv
// self-checking bench for the chip reset state controller
// assumes the controller stands alone; every input is driven here at the rising edge
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import chip_reset_pkg::*;
  localparam logic [NUM_APB-1:0] APB_KEEP =
    NUM_APB'((1 << APB_WDT) | (1 << APB_EMIF) | (1 << APB_DMAX));
  localparam logic [35:0]        START_EXP = {BOOT_ADDR, 1'b1, WDT_CLK_LFO, CLK_SEL_INT, 1'b0};
  logic                clk_sys_i    = 1'b0;
  logic                reset_i      = 1'b1;
  logic [NUM_SRC-1:0]  reset_src_i  = '0;
  logic                pullup_wr_i  = 1'b0;
  logic [NUM_PINS-1:0] pullup_val_i = '0;
  logic core_halt_o, regs_reset_o, por_regs_reset_o, pins_force_o, irq_disable_o;
  logic timer_disable_o, reset_pin_o, reset_pin_oe_o, pc_load_o, sysclk_sel_o;
  logic wdt_enable_o, wdt_clk_sel_o;
  logic [NUM_PINS-1:0] port_latch_o, port_open_drain_o, port_pullup_o, pv;
  logic [NUM_AHB-1:0]  ahb_clk_en_o;
  logic [NUM_APB-1:0]  apb_clk_en_o;
  logic [31:0]         pc_value_o;
  logic [35:0]         exp_q[$];
  logic [35:0]         got_start;
  logic                last_load = 1'b0;
  int                  error_cnt = 0;
  int                  checks_done = 0;

  chip_reset_state_controller DUT (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .reset_src_i(reset_src_i),
    .pullup_wr_i(pullup_wr_i), .pullup_val_i(pullup_val_i), .core_halt_o(core_halt_o),
    .regs_reset_o(regs_reset_o), .por_regs_reset_o(por_regs_reset_o),
    .pins_force_o(pins_force_o), .port_latch_o(port_latch_o),
    .port_open_drain_o(port_open_drain_o), .port_pullup_o(port_pullup_o),
    .irq_disable_o(irq_disable_o), .timer_disable_o(timer_disable_o),
    .ahb_clk_en_o(ahb_clk_en_o), .apb_clk_en_o(apb_clk_en_o), .reset_pin_o(reset_pin_o),
    .reset_pin_oe_o(reset_pin_oe_o), .pc_load_o(pc_load_o), .pc_value_o(pc_value_o),
    .sysclk_sel_o(sysclk_sel_o), .wdt_enable_o(wdt_enable_o), .wdt_clk_sel_o(wdt_clk_sel_o));

  always #50 clk_sys_i = ~clk_sys_i;

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask

  task automatic chk_level(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_start(input logic [35:0] got, input logic [35:0] exp);
    chk_level({28'h000_0000, got}, {28'h000_0000, exp});
  endtask

  task automatic print_verdict();
    $display("checks_done=%0d error_cnt=%0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // start-of-run record is taken when the load pulse shows; a pulse two cycles long is an error
  always @(negedge clk_sys_i)
  begin
    if (pc_load_o === 1'b1 && last_load === 1'b1)
      chk_level(64'h2, 64'h1);
    else if (pc_load_o === 1'b1 && exp_q.size() == 0)
      chk_level(64'h0, 64'h1);
    else if (pc_load_o === 1'b1)
    begin
      got_start = {pc_value_o, wdt_enable_o, wdt_clk_sel_o, sysclk_sel_o, core_halt_o};
      chk_start(got_start, exp_q.pop_front());
    end
    last_load = pc_load_o;
  end

  initial
  begin
    void'($urandom(1077));
    cyc(2);
    reset_i <= 1'b0;
    exp_q.push_back(START_EXP);
    for (int k = 0; k < NUM_SRC; k++)
    begin
      cyc(8);
      reset_src_i <= NUM_SRC'(1 << k);
      cyc(4);
      pullup_wr_i  <= 1'b1;
      pullup_val_i <= NUM_PINS'($urandom);
      cyc(1);
      pullup_wr_i <= 1'b0;
      @(negedge clk_sys_i);
      chk_level({core_halt_o, regs_reset_o, pins_force_o}, 64'h7);
      chk_level({irq_disable_o, timer_disable_o}, 64'h3);
      chk_level(ahb_clk_en_o, {NUM_AHB{1'b1}});
      chk_level(apb_clk_en_o, APB_KEEP);
      chk_level({port_latch_o, port_open_drain_o}, {2*NUM_PINS{1'b1}});
      chk_level(port_pullup_o, {NUM_PINS{1'b1}});
      chk_level(por_regs_reset_o, k < 2);
      chk_level({reset_pin_oe_o, reset_pin_o}, {k >= 2, 1'b0});
      cyc(1);
      reset_src_i <= '0;
      exp_q.push_back(START_EXP);
      cyc(8);
      pv = NUM_PINS'($urandom);
      pullup_wr_i  <= 1'b1;
      pullup_val_i <= pv;
      cyc(1);
      pullup_wr_i <= 1'b0;
      cyc(1);
      @(negedge clk_sys_i);
      chk_level({port_pullup_o, port_latch_o}, {pv, {NUM_PINS{1'b1}}});
      chk_level({core_halt_o, reset_pin_oe_o, reset_pin_o}, 64'h2);
    end
    // overlapping sources: dropping one must not release while another still holds
    cyc(1);
    reset_src_i <= 4'h5;
    cyc(5);
    reset_src_i <= 4'h4;
    cyc(5);
    @(negedge clk_sys_i);
    chk_level({core_halt_o, pins_force_o}, 64'h3);
    chk_level(reset_pin_oe_o, 64'h0);
    cyc(1);
    reset_src_i <= '0;
    exp_q.push_back(START_EXP);
    cyc(8);
    reset_i <= 1'b1;
    cyc(3);
    @(negedge clk_sys_i);
    chk_level(core_halt_o, 64'h1);
    chk_level(reset_pin_oe_o, 64'h1);
    cyc(1);
    reset_i <= 1'b0;
    exp_q.push_back(START_EXP);
    cyc(8);
    chk_level(exp_q.size(), 64'h0);
    print_verdict();
  end

  initial
  begin
    cyc(2000);
    error_cnt++;
    print_verdict();
  end
endmodule // tb_top
`default_nettype wire
